// ---- hw/ccca_accum.sv ----
// Purpose: one 32-bit coulomb accumulator
// Assumes: inc is a one-cycle pulse on ref_clk
// Notes: no overflow indication

module ccca_accum (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic inc,
  input wire logic clear,
  output logic [31:0] count_reg
);

  logic [31:0] count_next;

  // clear wins; plain add wraps back to zero
  assign count_next = clear ? ccca_pkg::ACC_RESET :
                      (inc ? count_reg + 32'h0000_0001 : count_reg);

  // ==========================================================
  // counter register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= ccca_pkg::ACC_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule // ccca_accum

// ---- hw/ccca_oc_path.sv ----
// Purpose: overcurrent latch and gate driver of one path
// Assumes: cmp_level already synchronised to ref_clk
// Notes: gate_oe high pulls the gate pin to ground

module ccca_oc_path (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cmp_level,
  input wire logic high_bit,
  input wire logic low_bit,
  input wire logic clear,
  output logic event_pulse,
  output logic latch_reg,
  output logic gate_oe_reg
);

  logic cmp_d_reg;
  logic latch_next;
  logic gate_oe_next;

  // rising comparator edge is the event
  assign event_pulse = cmp_level & ~cmp_d_reg;
  // set wins over clear
  assign latch_next = event_pulse | (latch_reg & ~clear);
  // truth table of force bits and latch
  assign gate_oe_next = ({high_bit, low_bit} == 2'h0) ? ~latch_reg :
                        ({high_bit, low_bit} == 2'h1) ? 1'b1 :
                        ({high_bit, low_bit} == 2'h2) ? 1'b0 :
                        ~cmp_level;

  // ==========================================================
  // latch and gate register; gate released during reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cmp_d_reg <= 1'b0;
      latch_reg <= 1'b0;
      gate_oe_reg <= 1'b0;
    end else begin
      cmp_d_reg <= cmp_level;
      latch_reg <= latch_next;
      gate_oe_reg <= gate_oe_next;
    end
  end

endmodule // ccca_oc_path

// ---- hw/ccca_pkg.sv ----
// Purpose: shared constants and types for the coulomb counter command and alert block
// Assumes: one 200 MHz ref_clk, serial bus pins sampled through synchronisers
// Notes: configuration bit positions are fixed here and used everywhere; status_word in ccca_top is built by position without the ST_ constants
//
// Function
// - separate charge and discharge 32-bit accumulators
// - accumulators zero on reset or clear bit
// - snapshot copies selected accumulator per command
// - command 0x82 enables updates, returns low half
// - command 0x83 disables updates, returns upper half
// - command 0x84 returns status, high byte ones
// - equality match sets flag and raises alert
// - reset zeroes threshold and disables comparison
// - command 0x00 writes low threshold, masks compare
// - command 0x01 writes upper threshold, unmasks compare
// - command 0x04 loads configuration word
// - reversal flag sets on reversal, stays set
// - reversal flag clears by clear, sleep, reset
// - reversal irq enable raises alert on flag
// - overcurrent sets latch and alert until cleared
// - overcurrent alerts regardless of force bits
// - both path bits one: gate follows comparator
// - free running alert latches on first event
// - gate output from high, low bits, latch
// - alert held until clear, sleep entry, response address, reset
// - accumulator overflow wraps silently to zero
// - snapshot loads on clock fall after command ack

package ccca_pkg;

  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_WR_LO = 8'h00;
  localparam logic [7:0] CMD_WR_HI = 8'h01;
  localparam logic [7:0] CMD_WR_CFG = 8'h04;
  localparam logic [7:0] CMD_RD_LO = 8'h82;
  localparam logic [7:0] CMD_RD_HI = 8'h83;
  localparam logic [7:0] CMD_RD_STAT = 8'h84;

  // ==========================================================
  // alert response address and reply
  localparam logic [6:0] ARA_ADDR = 7'h0C;
  localparam logic [7:0] ARA_REPLY = 8'h8F;
  localparam logic [7:0] STAT_FILL = 8'hFF;
  localparam logic [15:0] UNKNOWN_WORD = 16'hFFFF;

  // ==========================================================
  // configuration word bit positions
  localparam int CFG_CHG_LOW = 0;
  localparam int CFG_CHG_HIGH = 1;
  localparam int CFG_DIS_LOW = 2;
  localparam int CFG_DIS_HIGH = 3;
  localparam int CFG_EQ_EN = 4;
  localparam int CFG_ACC_SEL = 5;
  localparam int CFG_CLR_ACC = 6;
  localparam int CFG_CLR_ALERT = 7;
  localparam int CFG_REV_IRQ_EN = 8;
  localparam int CFG_SLEEP = 9;
  // write-one strobes are never stored
  localparam logic [15:0] CFG_STROBES = 16'h00C0;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // ==========================================================
  // status word bit positions
  localparam int ST_CHG_OC = 0;
  localparam int ST_DIS_OC = 1;
  localparam int ST_EQ = 2;
  localparam int ST_REV = 3;
  localparam int ST_SLEEP = 4;
  localparam int ST_DIR = 5;

  // ==========================================================
  // reset values and bit counts
  localparam logic [31:0] ACC_RESET = 32'h0000_0000;
  localparam logic [31:0] THR_RESET = 32'h0000_0000;
  localparam logic [5:0] SYNC_RESET = 6'h03;
  localparam logic [3:0] BIT_BYTE = 4'h8;
  localparam logic [3:0] BIT_ACK = 4'h9;

  // ==========================================================
  // serial slave states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_CMD = 3'b010,
    ST_WLO = 3'b011,
    ST_WHI = 3'b100,
    ST_RLO = 3'b101,
    ST_RHI = 3'b110,
    ST_TARA = 3'b111
  } ccca_state_t;

endpackage : ccca_pkg

// ---- hw/ccca_top.sv ----
// Purpose: serial slave, accumulators, compare, reversal and alert logic
// Assumes: scl and sda come straight from pins; master drives scl
// Notes: all pin inputs pass two flip-flops before use

module ccca_top #(
  // slave address, arbitrary default
  parameter logic [6:0] DEVICE_ADDR = 7'h36
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic charge_count_pulse,
  input wire logic discharge_count_pulse,
  input wire logic charge_comparator_out,
  input wire logic discharge_comparator_out,
  output logic charge_gate_out,
  output logic charge_gate_oe,
  output logic discharge_gate_out,
  output logic discharge_gate_oe,
  output logic alert_n_out,
  output logic alert_n_oe
);

  // ==========================================================
  // declarations
  logic [5:0] pin_raw;
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic [5:0] prev_reg;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  ccca_pkg::ccca_state_t state_reg;
  ccca_pkg::ccca_state_t state_next;
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic sda_oe_reg;
  logic sda_oe_next;
  logic ack_reg;
  logic ack_next;
  logic master_ack_reg;
  logic [7:0] cmd_reg;
  logic cmd_ok_reg;
  logic [7:0] wlo_reg;
  logic [15:0] word_reg;
  logic [15:0] rd_word;
  logic is_rx;
  logic is_tx;
  logic addr_w_hit;
  logic addr_r_hit;
  logic ara_hit;
  logic ack_want;

  logic ev_mask;
  logic ev_cmd;
  logic ev_wlo;
  logic ev_wdone;
  logic ev_rd_addr;
  logic ev_ara;
  logic wr_cfg;

  logic [15:0] cfg_reg;
  logic [31:0] thr_reg;
  logic [31:0] snap_reg;
  logic snap_en_reg;
  logic [31:0] chg_acc;
  logic [31:0] dis_acc;
  logic [31:0] sel_acc;
  logic sleep;
  logic sleep_d_reg;
  logic sleep_entry;
  logic chg_inc;
  logic dis_inc;
  logic clr_acc;
  logic clr_flags;

  logic eq_hit;
  logic eq_hit_d_reg;
  logic eq_event;
  logic eq_flag_reg;
  logic eq_mask_reg;
  logic dir_reg;
  logic dir_valid_reg;
  logic rev_now;
  logic rev_event;
  logic rev_flag_reg;
  logic chg_oc_event;
  logic dis_oc_event;
  logic chg_latch;
  logic dis_latch;
  logic alert_set;
  logic alert_reg;
  logic [7:0] status_word;

  // ==========================================================
  // pin synchronisers, then edge history
  assign pin_raw = {discharge_comparator_out, charge_comparator_out,
                    discharge_count_pulse, charge_count_pulse, sda_in, scl_in};

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= ccca_pkg::SYNC_RESET;
      sync2_reg <= ccca_pkg::SYNC_RESET;
      prev_reg <= ccca_pkg::SYNC_RESET;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // bus conditions from synchronised pins
  assign scl_s = sync2_reg[0];
  assign sda_s = sync2_reg[1];
  assign scl_rise = scl_s & ~prev_reg[0];
  assign scl_fall = ~scl_s & prev_reg[0];
  assign start_cond = scl_s & prev_reg[0] & prev_reg[1] & ~sda_s;
  assign stop_cond = scl_s & prev_reg[0] & ~prev_reg[1] & sda_s;

  // ==========================================================
  // serial slave decode
  assign is_rx = (state_reg == ccca_pkg::ST_ADDR) || (state_reg == ccca_pkg::ST_CMD) ||
                 (state_reg == ccca_pkg::ST_WLO) || (state_reg == ccca_pkg::ST_WHI);
  assign is_tx = (state_reg == ccca_pkg::ST_RLO) || (state_reg == ccca_pkg::ST_RHI) ||
                 (state_reg == ccca_pkg::ST_TARA);
  assign addr_w_hit = (shift_reg[7:1] == DEVICE_ADDR) & ~shift_reg[0];
  assign addr_r_hit = (shift_reg[7:1] == DEVICE_ADDR) & shift_reg[0] & cmd_ok_reg;
  assign ara_hit = (shift_reg[7:1] == ccca_pkg::ARA_ADDR) & shift_reg[0] & alert_reg;
  assign ack_want = (state_reg == ccca_pkg::ST_ADDR) ?
                    (addr_w_hit | addr_r_hit | ara_hit) : is_rx;

  // read word selected by the stored command
  assign rd_word = (cmd_reg == ccca_pkg::CMD_RD_LO) ? snap_reg[15:0] :
                   (cmd_reg == ccca_pkg::CMD_RD_HI) ? snap_reg[31:16] :
                   (cmd_reg == ccca_pkg::CMD_RD_STAT) ?
                   {ccca_pkg::STAT_FILL, status_word} :
                   ccca_pkg::UNKNOWN_WORD;

  // first bit driven at once, rest held for shifting
  function automatic logic [8:0] tx_load(input logic [7:0] b);
    return {~b[7], b[6:0], 1'b0};
  endfunction

  // ==========================================================
  // slave state machine next state
  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    sda_oe_next = sda_oe_reg;
    tx_next = tx_reg;
    ack_next = ack_reg;
    if (stop_cond) begin
      state_next = ccca_pkg::ST_IDLE;
      bit_cnt_next = 4'h0;
      sda_oe_next = 1'b0;
    end else if (start_cond) begin
      state_next = ccca_pkg::ST_ADDR;
      bit_cnt_next = 4'h0;
      sda_oe_next = 1'b0;
    end else if (state_reg != ccca_pkg::ST_IDLE) begin
      if (scl_rise && bit_cnt_reg < ccca_pkg::BIT_ACK) begin
        bit_cnt_next = bit_cnt_reg + 4'h1;
      end else if (scl_fall && bit_cnt_reg == ccca_pkg::BIT_BYTE) begin
        ack_next = ack_want;
        sda_oe_next = ack_want;
      end else if (scl_fall && bit_cnt_reg == ccca_pkg::BIT_ACK) begin
        bit_cnt_next = 4'h0;
        sda_oe_next = 1'b0;
        unique case (state_reg)
          ccca_pkg::ST_ADDR: begin
            if (!ack_reg) begin
              state_next = ccca_pkg::ST_IDLE;
            end else if (addr_w_hit) begin
              state_next = ccca_pkg::ST_CMD;
            end else if (addr_r_hit) begin
              state_next = ccca_pkg::ST_RLO;
              {sda_oe_next, tx_next} = tx_load(rd_word[7:0]);
            end else begin
              state_next = ccca_pkg::ST_TARA;
              {sda_oe_next, tx_next} = tx_load(ccca_pkg::ARA_REPLY);
            end
          end
          ccca_pkg::ST_CMD: begin
            state_next = ccca_pkg::ST_WLO;
          end
          ccca_pkg::ST_WLO: begin
            state_next = ccca_pkg::ST_WHI;
          end
          ccca_pkg::ST_RLO: begin
            if (master_ack_reg) begin
              state_next = ccca_pkg::ST_RHI;
              {sda_oe_next, tx_next} = tx_load(word_reg[15:8]);
            end else begin
              state_next = ccca_pkg::ST_IDLE;
            end
          end
          default: begin
            state_next = ccca_pkg::ST_IDLE;
          end
        endcase
      end else if (scl_fall && is_tx && bit_cnt_reg != 4'h0) begin
        sda_oe_next = ~tx_reg[7];
        tx_next = {tx_reg[6:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // slave state registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ccca_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
      tx_reg <= 8'h00;
      ack_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      sda_oe_reg <= sda_oe_next;
      tx_reg <= tx_next;
      ack_reg <= ack_next;
    end
  end

  // bus events
  assign ev_mask = scl_rise & (state_reg == ccca_pkg::ST_CMD) &
                   (bit_cnt_reg == ccca_pkg::BIT_BYTE) &
                   (shift_reg == ccca_pkg::CMD_WR_LO);
  assign ev_cmd = scl_fall & (state_reg == ccca_pkg::ST_CMD) &
                  (bit_cnt_reg == ccca_pkg::BIT_ACK);
  assign ev_wlo = scl_fall & (state_reg == ccca_pkg::ST_WLO) &
                  (bit_cnt_reg == ccca_pkg::BIT_ACK);
  assign ev_wdone = scl_fall & (state_reg == ccca_pkg::ST_WHI) &
                    (bit_cnt_reg == ccca_pkg::BIT_ACK);
  assign ev_rd_addr = scl_fall & (state_reg == ccca_pkg::ST_ADDR) &
                      (bit_cnt_reg == ccca_pkg::BIT_ACK) & ack_reg & addr_r_hit;
  assign ev_ara = scl_fall & (state_reg == ccca_pkg::ST_ADDR) &
                  (bit_cnt_reg == ccca_pkg::BIT_ACK) & ack_reg &
                  ~addr_w_hit & ~addr_r_hit;
  assign wr_cfg = ev_wdone & (cmd_reg == ccca_pkg::CMD_WR_CFG);

  // ==========================================================
  // received bytes and command context
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      shift_reg <= 8'h00;
      master_ack_reg <= 1'b0;
      cmd_reg <= 8'h00;
      cmd_ok_reg <= 1'b0;
      wlo_reg <= 8'h00;
      word_reg <= 16'h0000;
    end else begin
      if (scl_rise && is_rx && bit_cnt_reg < ccca_pkg::BIT_BYTE) begin
        shift_reg <= {shift_reg[6:0], sda_s};
      end
      if (scl_rise && is_tx && bit_cnt_reg == ccca_pkg::BIT_BYTE) begin
        master_ack_reg <= ~sda_s;
      end
      if (ev_cmd) begin
        cmd_reg <= shift_reg;
      end
      cmd_ok_reg <= ev_cmd | (cmd_ok_reg & ~stop_cond);
      if (ev_wlo) begin
        wlo_reg <= shift_reg;
      end
      if (ev_rd_addr) begin
        word_reg <= rd_word;
      end
    end
  end

  // ==========================================================
  // configuration, threshold and snapshot
  assign clr_acc = wr_cfg & wlo_reg[ccca_pkg::CFG_CLR_ACC];
  assign sleep = cfg_reg[ccca_pkg::CFG_SLEEP];
  assign sleep_entry = sleep & ~sleep_d_reg;
  assign clr_flags = (wr_cfg & wlo_reg[ccca_pkg::CFG_CLR_ALERT]) | sleep_entry;
  assign sel_acc = cfg_reg[ccca_pkg::CFG_ACC_SEL] ? dis_acc : chg_acc;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_reg <= ccca_pkg::CFG_RESET;
      thr_reg <= ccca_pkg::THR_RESET;
      sleep_d_reg <= 1'b0;
    end else begin
      sleep_d_reg <= sleep;
      if (wr_cfg) begin
        cfg_reg <= {shift_reg, wlo_reg} & ~ccca_pkg::CFG_STROBES;
      end
      if (ev_wdone && cmd_reg == ccca_pkg::CMD_WR_LO) begin
        thr_reg[15:0] <= {shift_reg, wlo_reg};
      end
      if (ev_wdone && cmd_reg == ccca_pkg::CMD_WR_HI) begin
        thr_reg[31:16] <= {shift_reg, wlo_reg};
      end
    end
  end

  // snapshot loads on the fall after the command ack
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      snap_reg <= ccca_pkg::ACC_RESET;
      snap_en_reg <= 1'b0;
    end else if (ev_cmd) begin
      if (shift_reg == ccca_pkg::CMD_RD_LO) begin
        snap_en_reg <= 1'b1;
        snap_reg <= sel_acc;
      end else if (shift_reg == ccca_pkg::CMD_RD_HI) begin
        snap_en_reg <= 1'b0;
      end else if (snap_en_reg) begin
        snap_reg <= sel_acc;
      end
    end
  end

  // ==========================================================
  // accumulators, counting stops in soft sleep
  assign chg_inc = sync2_reg[2] & ~prev_reg[2] & ~sleep;
  assign dis_inc = sync2_reg[3] & ~prev_reg[3] & ~sleep;

  ccca_accum u_chg_acc (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .inc(chg_inc),
    .clear(clr_acc),
    .count_reg(chg_acc)
  );

  ccca_accum u_dis_acc (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .inc(dis_inc),
    .clear(clr_acc),
    .count_reg(dis_acc)
  );

  // ==========================================================
  // overcurrent paths
  ccca_oc_path u_chg_path (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .cmp_level(sync2_reg[4]),
    .high_bit(cfg_reg[ccca_pkg::CFG_CHG_HIGH]),
    .low_bit(cfg_reg[ccca_pkg::CFG_CHG_LOW]),
    .clear(clr_flags),
    .event_pulse(chg_oc_event),
    .latch_reg(chg_latch),
    .gate_oe_reg(charge_gate_oe)
  );

  ccca_oc_path u_dis_path (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .cmp_level(sync2_reg[5]),
    .high_bit(cfg_reg[ccca_pkg::CFG_DIS_HIGH]),
    .low_bit(cfg_reg[ccca_pkg::CFG_DIS_LOW]),
    .clear(clr_flags),
    .event_pulse(dis_oc_event),
    .latch_reg(dis_latch),
    .gate_oe_reg(discharge_gate_oe)
  );

  // ==========================================================
  // equality compare and reversal detection
  assign eq_hit = cfg_reg[ccca_pkg::CFG_EQ_EN] & (sel_acc == thr_reg);
  assign eq_event = eq_hit & ~eq_hit_d_reg;
  assign rev_now = dir_valid_reg & ((chg_inc & ~dir_reg) | (dis_inc & dir_reg));
  assign rev_event = rev_now & ~rev_flag_reg;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      eq_hit_d_reg <= 1'b0;
      eq_flag_reg <= 1'b0;
      eq_mask_reg <= 1'b0;
      dir_reg <= 1'b0;
      dir_valid_reg <= 1'b0;
      rev_flag_reg <= 1'b0;
    end else begin
      eq_hit_d_reg <= eq_hit;
      eq_flag_reg <= eq_hit | (eq_flag_reg & ~clr_flags);
      // mask at ack rise of the low write, unmask after the high write
      eq_mask_reg <= ev_mask |
                     (eq_mask_reg & ~(ev_wdone & cmd_reg == ccca_pkg::CMD_WR_HI));
      if (chg_inc || dis_inc) begin
        dir_reg <= chg_inc;
        dir_valid_reg <= 1'b1;
      end
      rev_flag_reg <= rev_now | (rev_flag_reg & ~clr_flags);
    end
  end

  // ==========================================================
  // alert collection; a set wins over every clear
  assign alert_set = chg_oc_event | dis_oc_event |
                     (eq_event & ~eq_mask_reg) |
                     (rev_event & cfg_reg[ccca_pkg::CFG_REV_IRQ_EN]);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      alert_reg <= 1'b0;
    end else begin
      alert_reg <= alert_set | (alert_reg & ~(clr_flags | ev_ara));
    end
  end

  // status word
  assign status_word = {2'b00, dir_reg, sleep, rev_flag_reg, eq_flag_reg, dis_latch, chg_latch};

  // ==========================================================
  // open-drain pins only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_reg;
  assign charge_gate_out = 1'b0;
  assign discharge_gate_out = 1'b0;
  assign alert_n_out = 1'b0;
  assign alert_n_oe = alert_reg;

endmodule // ccca_top

// ---- sim/ccca_chk_sva.sv ----
// Purpose: port checks of the block
// Assumes: bound into ccca_top
// Notes: one clock domain
module ccca_chk (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic charge_comparator_out,
  input wire logic discharge_comparator_out,
  input wire logic charge_gate_oe,
  input wire logic discharge_gate_oe,
  input wire logic alert_n_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // ========
  // assertions
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  AST_CHG_ALERT: assert property (
    $rose(charge_comparator_out) |-> ##[1:8] alert_n_oe) else $error("no charge alert");
  AST_DIS_ALERT: assert property (
    $rose(discharge_comparator_out) |-> ##[1:8] alert_n_oe) else $error("no dis alert");
  AST_ALERT_HOLD: assert property ($fell(alert_n_oe) |-> !scl_in)
    else $error("alert dropped");
  AST_ALERT_STICKY: assert property (alert_n_oe && scl_in |=> alert_n_oe)
    else $error("alert not held");
  AST_CHG_GATE_RST: assert property (
    $rose(resetn) && !charge_comparator_out |-> ##[1:3] charge_gate_oe)
    else $error("charge gate off");
  AST_DIS_GATE_RST: assert property (
    $rose(resetn) && !discharge_comparator_out |-> ##[1:3] discharge_gate_oe)
    else $error("dis gate off");
  AST_SDA_ROSE: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("sda pulled in high scl");
  AST_SDA_HOLD: assert property (sda_oe && scl_in |=> sda_oe)
    else $error("sda released in high scl");
  cover property ($rose(alert_n_oe));
  cover property ($fell(alert_n_oe));
  cover property ($fell(discharge_gate_oe));
endmodule // ccca_chk

// ---- sim/ccca_host.sv ----
// Purpose: smbus master model
// Assumes: 16 ref_clk per scl bit
// Notes: sda is wired-and with pull-up
module ccca_host #(
  parameter logic [6:0] ADDR = 7'h36
) (
  input wire logic clk,
  input wire logic dut_oe,
  output logic scl,
  output wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pull = 1'b0;
  // ========
  // wire level and timing
  assign sda = !(pull | dut_oe);
  initial scl = 1'b1;
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one bit, sampled late in high phase
  task automatic bt(input logic d, output logic r);
    pull = !d;
    tk(4);
    scl = 1'b1;
    tk(7);
    r = sda;
    tk(1);
    scl = 1'b0;
    tk(4);
  endtask
  // byte then ack bit, ak pulls ack
  task automatic by(input logic [7:0] d, input logic ak, output logic [7:0] q);
    logic n;
    for (int i = 7; i >= 0; i--) begin
      bt(d[i], q[i]);
    end
    bt(!ak, n);
  endtask
  task automatic st();
    pull = 1'b0;
    tk(2);
    scl = 1'b1;
    tk(4);
    pull = 1'b1;
    tk(4);
    scl = 1'b0;
    tk(4);
  endtask
  task automatic sp();
    pull = 1'b1;
    tk(4);
    scl = 1'b1;
    tk(4);
    pull = 1'b0;
    tk(8);
  endtask
  // ========
  // transactions
  task automatic wr(input logic [7:0] c, input logic [15:0] w);
    logic [7:0] q;
    st();
    by({ADDR, 1'b0}, 1'b0, q);
    by(c, 1'b0, q);
    by(w[7:0], 1'b0, q);
    by(w[15:8], 1'b0, q);
    sp();
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] r);
    logic [7:0] q;
    st();
    by({ADDR, 1'b0}, 1'b0, q);
    by(c, 1'b0, q);
    st();
    by({ADDR, 1'b1}, 1'b0, q);
    by(8'hFF, 1'b1, r[7:0]);
    by(8'hFF, 1'b0, r[15:8]);
    sp();
  endtask
  task automatic ara(output logic [7:0] r);
    st();
    by({7'h0C, 1'b1}, 1'b0, r);
    by(8'hFF, 1'b0, r);
    sp();
  endtask
endmodule // ccca_host

// ---- sim/ccca_tb_top.sv ----
// Purpose: self-checking bench of the block
// Assumes: host model drives the bus
// Notes: checker bound below
bind ccca_top ccca_chk u_chk (.ref_clk, .resetn, .scl_in, .sda_oe, .charge_comparator_out,
  .discharge_comparator_out, .charge_gate_oe, .discharge_gate_oe, .alert_n_oe);
module ccca_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic resetn, cp, dp, cc, dc, sda_oe, c_oe, d_oe, a_oe;
  wire scl, sda;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [15:0] q;
  logic [7:0] b;
  logic [15:0] md [4] = '{16'h0084, 16'h0088, 16'h0080, 16'h008C};
  logic [1:0] ge [4] = '{2'b11, 2'b00, 2'b00, 2'b01};
  // ========
  // clock, design and host
  always #2.5 ref_clk = ~ref_clk;
  ccca_top u_dut (.ref_clk, .resetn, .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe,
    .charge_count_pulse(cp), .discharge_count_pulse(dp), .charge_comparator_out(cc),
    .discharge_comparator_out(dc), .charge_gate_out(), .charge_gate_oe(c_oe),
    .discharge_gate_out(), .discharge_gate_oe(d_oe), .alert_n_out(), .alert_n_oe(a_oe));
  ccca_host u_host (.clk(ref_clk), .dut_oe(sda_oe), .scl, .sda);
  // ========
  // tasks
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic pls(input logic ch, input int n);
    repeat (n) begin
      {cp, dp} = {ch, !ch};
      step(3);
      {cp, dp} = 2'b00;
      step(3);
    end
  endtask
  // snapshot, lower half then upper half
  task automatic cnt(input logic [31:0] e);
    u_host.rd(8'h82, q);
    chk(q, e[15:0]);
    u_host.rd(8'h83, q);
    chk(q, e[31:16]);
  endtask
  task automatic sts(input logic [7:0] e);
    u_host.rd(8'h84, q);
    chk(q, {8'hFF, e});
  endtask
  task automatic cfg(input logic [15:0] w);
    u_host.wr(8'h04, w);
  endtask
  task automatic test_done();
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ========
  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      test_done();
    end
  end
  // ========
  // sequence
  initial begin
    {resetn, cp, dp, cc, dc} = 5'h00;
    step(3);
    resetn = 1'b1;
    step(4);
    chk(16'({c_oe, d_oe, a_oe}), 16'h0006);
    sts(8'h00);
    pls(1'b1, 3);
    pls(1'b0, 2);
    cnt(32'h0000_0003);
    cfg(16'h0020);
    cnt(32'h0000_0002);
    sts(8'h08);
    cfg(16'h0080);
    sts(8'h00);
    cfg(16'h0100);
    pls(1'b1, 1);
    step(8);
    chk(16'(a_oe), 16'h0001);
    sts(8'h28);
    cfg(16'h0080);
    chk(16'(a_oe), 16'h0000);
    u_host.wr(8'h00, 16'h0006);
    u_host.wr(8'h01, 16'h0000);
    cfg(16'h0010);
    pls(1'b1, 2);
    step(8);
    chk(16'(a_oe), 16'h0001);
    sts(8'h24);
    cfg(16'h0080);
    cc = 1'b1;
    step(8);
    cc = 1'b0;
    step(8);
    chk(16'({c_oe, a_oe}), 16'h0001);
    u_host.ara(b);
    chk(16'({b, c_oe, a_oe}), 16'h023C);
    sts(8'h25);
    cfg(16'h0080);
    chk(16'(c_oe), 16'h0001);
    for (int i = 0; i < 4; i++) begin
      cfg(md[i]);
      dc = 1'b1;
      step(8);
      chk(16'({d_oe, a_oe}), 16'({ge[i][1], 1'b1}));
      dc = 1'b0;
      step(8);
      chk(16'({d_oe, a_oe}), 16'({ge[i][0], 1'b1}));
    end
    cfg(16'h0080);
    cfg(16'h0040);
    cnt(32'h0000_0000);
    test_done();
  end
endmodule // ccca_tb_top
